// File: design/periph_irq_enable_flag_bank.sv
// Peripheral interrupt enable and request flag bank with register port
//
// Contract
// - Enable register bits 7-6 and 3-2 read zero and ignore writes.
// - Enable bit 5 gates the second UART receive request.
// - Enable bit 4 gates the second UART transmit request.
// - Enable bit 1 gates the second sync serial collision request.
// - Enable bit 0 gates the second sync serial event request.
// - No peripheral interrupt without the peripheral gate bit set.
// - Flags set on their event regardless of any enable bit.
// - Flag bit 7 is timer gate, bit 6 is converter done.
// - Bits 5, 4, 3 are first UART receive, transmit, sync serial.
// - Bits 2, 1, 0 are capture/compare, period match, overflow.
// - Each flag reads one while pending, zero otherwise.
// - All implemented bits clear to zero on every reset.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module periph_irq_enable_flag_bank
	import irq_bank_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire reg_req_t    bus_req,
	output logic [7:0]       rdata,
	// Peripheral event pulses, same clock
	input  wire group_one_t  one_events,
	input  wire group_four_t four_events,
	// Flag clears from the first UART
	input  wire logic        uart_a_rx_clear,
	input  wire logic        uart_a_tx_clear,
	// Requests toward the core
	output logic             periph_irq_req,
	output logic             core_irq_req,
	// Bank health interrupt
	output logic             irq_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ser_en_reg,   ser_en_next;
	logic [7:0] req_one_reg,  req_one_next;
	logic [7:0] req_four_reg, req_four_next;
	logic [7:0] en_one_reg,   en_one_next;
	logic [7:0] core_reg,     core_next;
	logic [7:0] stat_reg,     stat_next;
	logic [7:0] irq_en_reg,   irq_en_next;
	logic [7:0] rdata_reg,    rdata_next;
	logic       preq_reg,     preq_next;
	logic       creq_reg,     creq_next;
	logic       irq_reg,      irq_next;

	// Decoded strobes and event vectors
	logic       wr_ser;
	logic       wr_one;
	logic       wr_four;
	logic       wr_en_one;
	logic       wr_core;
	logic       wr_clear;
	logic       wr_irq_en;
	logic [7:0] ev_one;
	logic [7:0] ev_four;
	logic [7:0] pend_one;
	logic [7:0] pend_four;
	logic       any_pend;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Only the write strobe qualifies writes; unmapped writes fall away
	assign wr_ser    = bus_req.wr && (bus_req.addr == OFS_SER_EN);
	assign wr_one    = bus_req.wr && (bus_req.addr == OFS_REQ_ONE);
	assign wr_four   = bus_req.wr && (bus_req.addr == OFS_REQ_FOUR);
	assign wr_en_one = bus_req.wr && (bus_req.addr == OFS_EN_ONE);
	assign wr_core   = bus_req.wr && (bus_req.addr == OFS_CORE_CTRL);
	assign wr_clear  = bus_req.wr && (bus_req.addr == OFS_CLEAR);
	assign wr_irq_en = bus_req.wr && (bus_req.addr == OFS_IRQ_EN);

	// ----------------------------------------------------------------
	// Event placement
	// ----------------------------------------------------------------
	// Struct field order already matches the first flag layout
	always_comb
	begin
		ev_one  = one_events;
		ev_four = 8'h00;
		ev_four[BIT_UART_B_RX]   = four_events.uart_b_rx;
		ev_four[BIT_UART_B_TX]   = four_events.uart_b_tx;
		ev_four[BIT_SYNC_B_COLL] = four_events.sync_serial_b_collision;
		ev_four[BIT_SYNC_B_IRQ]  = four_events.sync_serial_b_event;
	end

	// ----------------------------------------------------------------
	// Enable registers
	// ----------------------------------------------------------------
	// Masking at write time keeps unused positions at zero forever
	always_comb
	begin
		ser_en_next = ser_en_reg;
		en_one_next = en_one_reg;
		core_next   = core_reg;
		if (wr_ser)
		begin
			ser_en_next = bus_req.wdata & SER_MASK;
		end
		if (wr_en_one)
		begin
			en_one_next = bus_req.wdata;
		end
		if (wr_core)
		begin
			core_next = bus_req.wdata & CORE_MASK;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ser_en_reg <= SER_EN_RST;
			en_one_reg <= EN_ONE_RST;
			core_reg   <= CORE_RST;
		end
		else
		begin
			ser_en_reg <= ser_en_next;
			en_one_reg <= en_one_next;
			core_reg   <= core_next;
		end
	end

	// ----------------------------------------------------------------
	// Request flags
	// ----------------------------------------------------------------
	// Order: software write, then UART clear, then events; an event in
	// the clearing cycle survives because its set is applied last
	always_comb
	begin
		req_one_next  = req_one_reg;
		req_four_next = req_four_reg;
		if (wr_one)
		begin
			req_one_next = (bus_req.wdata & REQ_ONE_WMASK)
				| (req_one_reg & ~REQ_ONE_WMASK);
		end
		if (uart_a_rx_clear)
		begin
			req_one_next[BIT_UART_A_RX] = 1'b0;
		end
		if (uart_a_tx_clear)
		begin
			req_one_next[BIT_UART_A_TX] = 1'b0;
		end
		if (wr_four)
		begin
			req_four_next = bus_req.wdata & SER_MASK;
		end
		req_one_next  = req_one_next | ev_one;
		req_four_next = req_four_next | ev_four;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			req_one_reg  <= REQ_ONE_RST;
			req_four_reg <= REQ_FOUR_RST;
		end
		else
		begin
			req_one_reg  <= req_one_next;
			req_four_reg <= req_four_next;
		end
	end

	// ----------------------------------------------------------------
	// Request gating
	// ----------------------------------------------------------------
	// Gating uses registered flags, so a request follows its event by
	// two cycles; a stale flag fires at once when software enables it
	always_comb
	begin
		pend_one  = req_one_reg & en_one_reg;
		pend_four = 8'h00;
		pend_four[BIT_UART_B_RX] = req_four_reg[BIT_UART_B_RX]
			& ser_en_reg[BIT_UART_B_RX];
		pend_four[BIT_UART_B_TX] = req_four_reg[BIT_UART_B_TX]
			& ser_en_reg[BIT_UART_B_TX];
		pend_four[BIT_SYNC_B_COLL] = req_four_reg[BIT_SYNC_B_COLL]
			& ser_en_reg[BIT_SYNC_B_COLL];
		pend_four[BIT_SYNC_B_IRQ] = req_four_reg[BIT_SYNC_B_IRQ]
			& ser_en_reg[BIT_SYNC_B_IRQ];
		any_pend  = (|pend_one) || (|pend_four);
		preq_next = any_pend && core_reg[BIT_PERIPH_GATE];
		creq_next = preq_next && core_reg[BIT_GLOBAL_GATE];
	end

	// ----------------------------------------------------------------
	// Bank health status
	// ----------------------------------------------------------------
	// Overrun marks an event that hit a flag still set: one was lost
	always_comb
	begin
		stat_next = stat_reg;
		if (wr_clear)
		begin
			stat_next = stat_reg & ~bus_req.wdata;
		end
		if (preq_next && !preq_reg)
		begin
			stat_next[ST_REQ_RISE] = 1'b1;
		end
		if (|(ev_one & req_one_reg))
		begin
			stat_next[ST_OVR_ONE] = 1'b1;
		end
		if (|(ev_four & req_four_reg))
		begin
			stat_next[ST_OVR_FOUR] = 1'b1;
		end
		stat_next   = stat_next & STAT_MASK;
		irq_en_next = irq_en_reg;
		if (wr_irq_en)
		begin
			irq_en_next = bus_req.wdata & STAT_MASK;
		end
		irq_next = |(stat_next & irq_en_next);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stat_reg   <= STAT_RST;
			irq_en_reg <= IRQ_EN_RST;
			irq_reg    <= 1'b0;
			preq_reg   <= 1'b0;
			creq_reg   <= 1'b0;
		end
		else
		begin
			stat_reg   <= stat_next;
			irq_en_reg <= irq_en_next;
			irq_reg    <= irq_next;
			preq_reg   <= preq_next;
			creq_reg   <= creq_next;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Data stand for one cycle after the strobe and are zero otherwise
	always_comb
	begin
		rdata_next = 8'h00;
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				OFS_SER_EN:    rdata_next = ser_en_reg & SER_MASK;
				OFS_REQ_ONE:   rdata_next = req_one_reg;
				OFS_REQ_FOUR:  rdata_next = req_four_reg;
				OFS_EN_ONE:    rdata_next = en_one_reg;
				OFS_CORE_CTRL: rdata_next = core_reg;
				OFS_STATUS:    rdata_next = stat_reg;
				OFS_IRQ_EN:    rdata_next = irq_en_reg;
				default:       rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_reg <= 8'h00;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata          = rdata_reg;
	assign periph_irq_req = preq_reg;
	assign core_irq_req   = creq_reg;
	assign irq_out        = irq_reg;

endmodule // periph_irq_enable_flag_bank

`default_nettype wire

// File: design/irq_bank_pkg.sv
// Constants, register map and carrier types of the peripheral interrupt bank
package irq_bank_pkg;

	// ----------------------------------------------------------------
	// Register port widths and offsets
	// ----------------------------------------------------------------
	localparam int        ADDR_W        = 4;
	localparam int        DATA_W        = 8;
	localparam logic [3:0] OFS_SER_EN    = 4'h0;
	localparam logic [3:0] OFS_REQ_ONE   = 4'h1;
	localparam logic [3:0] OFS_CORE_CTRL = 4'h2;
	localparam logic [3:0] OFS_REQ_FOUR  = 4'h3;
	localparam logic [3:0] OFS_EN_ONE    = 4'h4;
	localparam logic [3:0] OFS_STATUS    = 4'h5;
	localparam logic [3:0] OFS_CLEAR     = 4'h6;
	localparam logic [3:0] OFS_IRQ_EN    = 4'h7;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_UART_B_RX    = 5;
	localparam int BIT_UART_B_TX    = 4;
	localparam int BIT_SYNC_B_COLL  = 1;
	localparam int BIT_SYNC_B_IRQ   = 0;
	localparam int BIT_TIMER_A_GATE = 7;
	localparam int BIT_ADC_DONE     = 6;
	localparam int BIT_UART_A_RX    = 5;
	localparam int BIT_UART_A_TX    = 4;
	localparam int BIT_SYNC_A       = 3;
	localparam int BIT_CAPCOMP_A    = 2;
	localparam int BIT_TIMER_B      = 1;
	localparam int BIT_TIMER_A_OVF  = 0;
	localparam int BIT_GLOBAL_GATE  = 7;
	localparam int BIT_PERIPH_GATE  = 6;
	localparam int ST_REQ_RISE      = 0;
	localparam int ST_OVR_ONE       = 1;
	localparam int ST_OVR_FOUR      = 2;

	// ----------------------------------------------------------------
	// Implemented-bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SER_MASK      = 8'h33;
	localparam logic [7:0] REQ_ONE_WMASK = 8'hcf;
	localparam logic [7:0] CORE_MASK     = 8'hc0;
	localparam logic [7:0] STAT_MASK     = 8'h07;
	localparam logic [7:0] SER_EN_RST    = 8'h00;
	localparam logic [7:0] REQ_ONE_RST   = 8'h00;
	localparam logic [7:0] CORE_RST      = 8'h00;
	localparam logic [7:0] REQ_FOUR_RST  = 8'h00;
	localparam logic [7:0] EN_ONE_RST    = 8'h00;
	localparam logic [7:0] STAT_RST      = 8'h00;
	localparam logic [7:0] IRQ_EN_RST    = 8'h00;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic timer_a_gate;
		logic adc_done;
		logic uart_a_rx;
		logic uart_a_tx;
		logic sync_serial_a;
		logic capcomp_a;
		logic timer_b_match;
		logic timer_a_overflow;
	} group_one_t;

	typedef struct packed {
		logic uart_b_rx;
		logic uart_b_tx;
		logic sync_serial_b_collision;
		logic sync_serial_b_event;
	} group_four_t;

endpackage

// File: verif/irq_bank_properties.sv
// Port-level assertions of the peripheral interrupt bank
`timescale 1ns/1ps
`default_nettype none
module irq_bank_properties
	import irq_bank_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Register port
	input wire reg_req_t   bus_req,
	input wire logic [7:0] rdata,
	// Events and requests
	input wire group_one_t one_events,
	input wire logic       periph_irq_req,
	input wire logic       core_irq_req,
	input wire logic       irq_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// Read port checks
	// ----
	a_rdata_one_cycle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("rdata outside read slot");
	a_ser_spare_zero: assert property (
		$past(bus_req.rd) && $past(bus_req.addr) == OFS_SER_EN |-> (rdata & ~SER_MASK) == 8'h00)
		else $error("enable spare bits not zero");
	a_unmapped_zero: assert property ($past(bus_req.rd)
		&& ($past(bus_req.addr) > 4'h7 || $past(bus_req.addr) == OFS_CLEAR) |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_core_spare_zero: assert property (
		$past(bus_req.rd) && $past(bus_req.addr) == OFS_CORE_CTRL |-> (rdata & ~CORE_MASK) == 8'h00)
		else $error("control spare bits not zero");
	a_stat_spare_zero: assert property ($past(bus_req.rd) && ($past(bus_req.addr) == OFS_STATUS
		|| $past(bus_req.addr) == OFS_IRQ_EN) |-> (rdata & ~STAT_MASK) == 8'h00)
		else $error("status spare bits not zero");
	// Bits 5-4 masked: the UART may clear them in between
	a_event_sets_flag: assert property (
		(one_events != 8'h00) ##1 !bus_req.wr ##1 (bus_req.rd && bus_req.addr == OFS_REQ_ONE)
		|=> (rdata & $past(one_events, 3) & 8'hcf) == ($past(one_events, 3) & 8'hcf))
		else $error("event did not set flag");
	a_core_needs_periph: assert property (core_irq_req |-> periph_irq_req)
		else $error("core request without peripheral request");
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !periph_irq_req && !core_irq_req && !irq_out && rdata == 8'h00)
		else $error("outputs not cleared by reset");
endmodule // irq_bank_properties

bind periph_irq_enable_flag_bank irq_bank_properties i_irq_bank_properties (
	.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .one_events(one_events),
	.periph_irq_req(periph_irq_req), .core_irq_req(core_irq_req), .irq_out(irq_out)
);
`default_nettype wire

// File: verif/periph_event_model.sv
// Behavioural peripheral event sources facing the bank
`timescale 1ns/1ps
`default_nettype none
module periph_event_model
	import irq_bank_pkg::*;
(
	// Clock
	input wire logic         clk,
	// Event and clear pulses
	output var group_one_t   one_events,
	output var group_four_t  four_events,
	output var logic         uart_a_rx_clear,
	output var logic         uart_a_tx_clear
);
	initial
	begin
		one_events = '0;
		four_events = '0;
		{uart_a_rx_clear, uart_a_tx_clear} = 2'b00;
	end
	// One-cycle pulse after a delay, so slow and prompt sources both occur;
	// always waits one edge first so a pulse never starts off the clock edge
	task automatic fire(input int dly, input group_one_t o, input group_four_t f, input logic [1:0] c);
		repeat (dly + 1) @(posedge clk);
		one_events <= o;
		four_events <= f;
		{uart_a_rx_clear, uart_a_tx_clear} <= c;
		@(posedge clk);
		one_events <= '0;
		four_events <= '0;
		{uart_a_rx_clear, uart_a_tx_clear} <= 2'b00;
	endtask
endmodule // periph_event_model
`default_nettype wire

// File: verif/periph_irq_enable_flag_bank_tb.sv
// Self-checking bench of the peripheral interrupt bank
`timescale 1ns/1ps
`default_nettype none
module periph_irq_enable_flag_bank_tb
	import irq_bank_pkg::*;
;
	typedef struct packed { logic [3:0] a; logic [7:0] d; logic [7:0] e; } row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	reg_req_t    req = '0;
	logic [7:0]  rdata;
	group_one_t  one_ev;
	group_four_t four_ev;
	logic        rxc, txc, pirq, cirq, irq;
	int          fails = 0, checks_done = 0, cyc = 0;
	logic [7:0]  fbit [4] = '{8'h20, 8'h10, 8'h02, 8'h01};
	row_t        rows [10] = '{'{OFS_SER_EN, 8'hff, 8'h33}, '{OFS_SER_EN, 8'hcc, 8'h00},
		'{OFS_CORE_CTRL, 8'hff, 8'hc0}, '{OFS_REQ_FOUR, 8'hff, 8'h33}, '{OFS_EN_ONE, 8'ha5, 8'ha5},
		'{OFS_IRQ_EN, 8'hff, 8'h07}, '{OFS_CLEAR, 8'hff, 8'h00}, '{4'hc, 8'hff, 8'h00},
		'{OFS_REQ_ONE, 8'hff, 8'hcf}, '{OFS_SER_EN, 8'h21, 8'h21}};

	always #2.5 clk = ~clk;
	periph_irq_enable_flag_bank i_periph_irq_enable_flag_bank (.clk(clk), .rst_n(rst_n), .bus_req(req),
		.rdata(rdata), .one_events(one_ev), .four_events(four_ev), .uart_a_rx_clear(rxc),
		.uart_a_tx_clear(txc), .periph_irq_req(pirq), .core_irq_req(cirq), .irq_out(irq));
	periph_event_model i_periph_event_model (.clk(clk), .one_events(one_ev), .four_events(four_ev),
		.uart_a_rx_clear(rxc), .uart_a_tx_clear(txc));
	// ----
	// Bus cycles and comparisons
	// ----
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		#1 cmp(rdata, e);
	endtask
	// Request levels settle two cycles after their cause
	task automatic lvl(input logic [2:0] e);
		repeat (2) @(posedge clk);
		#1 cmp({5'h00, cirq, irq, pirq}, {5'h00, e});
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails++;
			complete_run();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			chk(rows[i].a, rows[i].e);
		end
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) chk(4'(a), 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			i_periph_event_model.fire(i, group_one_t'(8'h01 << i), '0, 2'b00);
			chk(OFS_REQ_ONE, 8'hff >> (7 - i));
		end
		wr(OFS_REQ_ONE, 8'h00);
		chk(OFS_REQ_ONE, 8'h30);
		i_periph_event_model.fire(0, '0, '0, 2'b11);
		chk(OFS_REQ_ONE, 8'h00);
		wr(OFS_CORE_CTRL, 8'h40);
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_SER_EN, 8'h33 ^ fbit[k]);
			i_periph_event_model.fire(1, '0, group_four_t'(4'h8 >> k), 2'b00);
			lvl(3'b000);
			wr(OFS_SER_EN, fbit[k]);
			lvl(3'b001);
			wr(OFS_REQ_FOUR, 8'h00);
			lvl(3'b000);
		end
		wr(OFS_REQ_FOUR, 8'h01);
		wr(OFS_CORE_CTRL, 8'h80);
		lvl(3'b000);
		wr(OFS_CORE_CTRL, 8'hc0);
		lvl(3'b101);
		wr(OFS_CLEAR, 8'h07);
		chk(OFS_STATUS, 8'h00);
		wr(OFS_IRQ_EN, 8'h02);
		i_periph_event_model.fire(0, group_one_t'(8'h40), '0, 2'b00);
		i_periph_event_model.fire(1, group_one_t'(8'h40), '0, 2'b00);
		lvl(3'b111);
		chk(OFS_STATUS, 8'h02);
		wr(OFS_IRQ_EN, 8'h00);
		lvl(3'b101);
		wr(OFS_IRQ_EN, 8'h02);
		lvl(3'b111);
		wr(OFS_CLEAR, 8'h02);
		lvl(3'b101);
		// Group one path: the stale converter flag requests once enabled
		wr(OFS_REQ_FOUR, 8'h00);
		lvl(3'b000);
		wr(OFS_EN_ONE, 8'h40);
		lvl(3'b101);
		chk(OFS_STATUS, 8'h01);
		complete_run();
	end
endmodule // periph_irq_enable_flag_bank_tb
`default_nettype wire
